// ### adc_autoscan_sequencer.sv
// autoscan sequencer, triggers, watchdog and register file of the converter
`timescale 1ns/10ps
// Behaviour
// - converter clock is system clock halved, divided
// - sample 8 units, convert 28 units total
// - repeat bit selects continuous else single mode
// - start at first channel, step up to 15
// - first channel all ones converts channel 15 only
// - run bit starts scan, results stored per channel
// - single mode clears run bit after channel 15
// - continuous mode restarts at first channel, loops
// - sequence done request after every channel 15
// - new result overwrites old one, no buffer
// - masked pin and timer triggers ORed start
// - two adjacent watchdog channels checked against thresholds
// - two maskable requests, fixed order, priority level
// - power bit idles converter at low power
// - sixteen channels, ten bit results
// - triggers ignored while run bit set
// - result split high nine-two, low one-zero top
// - watchdog served first, sequence done held pending
module adc_autoscan_sequencer #(
	parameter int CHANNEL_COUNT = adc_pkg::CHANNELS,
	parameter int RESULT_WIDTH  = adc_pkg::RESULT_W
) (
	input  wire logic                        clock,
	input  wire logic                        reset,
	input  wire adc_pkg::reg_bus_type        bus,
	output logic [7:0]                       rd_data_q,
	input  wire logic                        external_trigger_input,
	input  wire logic                        timer_trigger_input,
	input  wire logic [adc_pkg::RESULT_W-1:0] conv_result,
	output logic [adc_pkg::CHAN_W-1:0]       analog_channel_q,
	output logic                             sampling_q,
	output logic                             converting_q,
	output logic                             power_enable_q,
	output logic                             converter_clock,
	output logic                             irq_request_q,
	output logic                             irq_watchdog_q,
	output logic [adc_pkg::PRIO_W-1:0]       irq_level_q
);
	import adc_pkg::*;

	if (CHANNEL_COUNT != CHANNELS || RESULT_WIDTH != RESULT_W) begin : size_check
		$error("sequencer serves sixteen channels of ten bits only");
	end

	logic [CHAN_W-1:0]   first_channel_field_q;
	logic [CHAN_W-1:0]   watchdog_channel_select_q;
	logic [DIV_W-1:0]    clock_divider_field_q;
	logic                power_on_q;
	logic                conversion_run_bit_q;
	logic                repeat_mode_q;
	logic                external_trigger_mask_q;
	logic                timer_trigger_mask_q;
	logic [7:0]          threshold_q [4];
	logic                window_alarm_flag_q;
	logic                sequence_done_flag_q;
	logic                alarm_mask_q;
	logic                done_mask_q;
	logic [PRIO_W-1:0]   priority_level_q;
	logic [3:0]          compare_flags_q;
	seq_state_type       state_q;
	logic [4:0]          unit_count_q;
	logic [CHAN_W-1:0]   chan_q;
	logic [2:0]          ext_hist_q;
	logic [2:0]          tmr_hist_q;
	logic                unit_tick;
	logic                active;
	logic                conv_done;
	logic                last_done;
	logic                trigger_event;
	logic                trigger_start;
	logic                wr_ctl1;
	logic                wr_ctl2;
	logic                wr_status;
	logic [3:0]          new_flags;
	logic [RESULT_W-1:0] read_result;
	logic [7:0]          read_value;
	logic                alarm_pend;
	logic                done_pend;
	result_write_type    result_wr;

	// exact byte address match
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit

	assign wr_ctl1   = bus.wr && hit(bus.addr, ADDR_CONTROL_ONE);
	assign wr_ctl2   = bus.wr && hit(bus.addr, ADDR_CONTROL_TWO);
	assign wr_status = bus.wr && hit(bus.addr, ADDR_STATUS);

	// trigger history, a pulse needs two low samples
	always_ff @(posedge clock) begin
		if (reset) begin
			ext_hist_q <= TRIG_IDLE;
			tmr_hist_q <= TRIG_IDLE;
		end else begin
			ext_hist_q <= {ext_hist_q[1:0], external_trigger_input};
			tmr_hist_q <= {tmr_hist_q[1:0], timer_trigger_input};
		end
	end

	// masked sources ORed into one start
	assign trigger_event = ((ext_hist_q == TRIG_SEEN) && external_trigger_mask_q)
		|| ((tmr_hist_q == TRIG_SEEN) && timer_trigger_mask_q);
	assign trigger_start = trigger_event && !conversion_run_bit_q;

	assign active    = conversion_run_bit_q && power_on_q;
	assign conv_done = (state_q == SEQ_CONVERT) && active && unit_tick
		&& (unit_count_q == CONV_UNITS - 5'h01);
	assign last_done = conv_done && (chan_q == LAST_CHANNEL);

	// control one: watchdog select and first channel
	always_ff @(posedge clock) begin
		if (reset) begin
			first_channel_field_q     <= CONTROL_RESET[FIRST_LSB +: CHAN_W];
			watchdog_channel_select_q <= CONTROL_RESET[WDSEL_LSB +: CHAN_W];
		end else if (wr_ctl1) begin
			first_channel_field_q     <= bus.wdata[FIRST_LSB +: CHAN_W];
			watchdog_channel_select_q <= bus.wdata[WDSEL_LSB +: CHAN_W];
		end
	end

	// control two: divider, power, mode and trigger masks
	always_ff @(posedge clock) begin
		if (reset) begin
			clock_divider_field_q   <= CONTROL_RESET[DIV_LSB +: DIV_W];
			power_on_q              <= CONTROL_RESET[POWER_BIT];
			repeat_mode_q           <= CONTROL_RESET[REPEAT_BIT];
			external_trigger_mask_q <= CONTROL_RESET[EXT_MASK_BIT];
			timer_trigger_mask_q    <= CONTROL_RESET[TMR_MASK_BIT];
		end else if (wr_ctl2) begin
			clock_divider_field_q   <= bus.wdata[DIV_LSB +: DIV_W];
			power_on_q              <= bus.wdata[POWER_BIT];
			repeat_mode_q           <= bus.wdata[REPEAT_BIT];
			external_trigger_mask_q <= bus.wdata[EXT_MASK_BIT];
			timer_trigger_mask_q    <= bus.wdata[TMR_MASK_BIT];
		end
	end

	// run bit set by software or trigger; trigger beats a software clear
	// single mode drops it after channel 15
	always_ff @(posedge clock) begin
		if (reset) begin
			conversion_run_bit_q <= CONTROL_RESET[RUN_BIT];
		end else if (trigger_start) begin
			conversion_run_bit_q <= 1'b1;
		end else if (wr_ctl2) begin
			conversion_run_bit_q <= bus.wdata[RUN_BIT];
		end else if (last_done && !repeat_mode_q) begin
			conversion_run_bit_q <= 1'b0;
		end
	end

	// prescaler only runs during a scan to save power between groups;
	// it starts with the run bit so the first unit is no longer than the rest
	adc_unit_prescaler prescaler (
		.clock             (clock),
		.reset             (reset),
		.enable            (active),
		.divider           (clock_divider_field_q),
		.unit_tick_q       (unit_tick),
		.converter_clock_q (converter_clock)
	);

	// repeat bit picks restart or stop
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q      <= SEQ_IDLE;
			unit_count_q <= 5'h00;
			chan_q       <= 4'h0;
		end else begin
			case (state_q)
				SEQ_IDLE: begin
					unit_count_q <= 5'h00;
					// all ones loads channel 15 directly
					if (active) begin
						state_q <= SEQ_SAMPLE;
						chan_q  <= first_channel_field_q;
					end
				end
				SEQ_SAMPLE: begin
					if (!active) begin
						state_q <= SEQ_IDLE;
					end else if (unit_tick) begin
						unit_count_q <= unit_count_q + 5'h01;
						if (unit_count_q == SAMPLE_UNITS - 5'h01) begin
							state_q <= SEQ_CONVERT;
						end
					end
				end
				SEQ_CONVERT: begin
					if (!active) begin
						state_q <= SEQ_IDLE;
					end else if (conv_done) begin
						unit_count_q <= 5'h00;
						if (chan_q != LAST_CHANNEL) begin
							chan_q  <= chan_q + 4'h1;
							state_q <= SEQ_SAMPLE;
						end else if (repeat_mode_q) begin
							// continuous loop back to first channel
							chan_q  <= first_channel_field_q;
							state_q <= SEQ_SAMPLE;
						end else begin
							state_q <= SEQ_IDLE;
						end
					end else if (unit_tick) begin
						unit_count_q <= unit_count_q + 5'h01;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	// store each result in its channel
	assign result_wr.en   = conv_done;
	assign result_wr.chan = chan_q;
	assign result_wr.data = conv_result;

	adc_result_store #(.DEPTH(CHANNELS)) results (
		.clock     (clock),
		.write     (result_wr),
		.read_chan (bus.addr[4:1]),
		.read_data (read_result)
	);

	// channel A at select, B next one up; upper is at or above, lower below
	always_comb begin
		new_flags = 4'h0;
		if (conv_done && chan_q == watchdog_channel_select_q) begin
			new_flags[3] = conv_result[9:2] >= threshold_q[0];
			new_flags[2] = conv_result[9:2] <  threshold_q[1];
		end
		if (conv_done && chan_q == watchdog_channel_select_q + 4'h1) begin
			new_flags[1] = conv_result[9:2] >= threshold_q[2];
			new_flags[0] = conv_result[9:2] <  threshold_q[3];
		end
	end

	// thresholds: upper A, lower A, upper B, lower B
	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				threshold_q[i] <= THRESH_RESET;
			end
		end else if (bus.wr && bus.addr[7:2] == ADDR_THRESH_BASE[7:2]) begin
			threshold_q[bus.addr[1:0]] <= bus.wdata;
		end
	end

	// compare flags clear with the alarm flag, new hits win
	always_ff @(posedge clock) begin
		if (reset) begin
			compare_flags_q <= 4'h0;
		end else if (wr_status && !bus.wdata[ALARM_BIT]) begin
			compare_flags_q <= new_flags;
		end else begin
			compare_flags_q <= compare_flags_q | new_flags;
		end
	end

	// sticky request flags, hardware set beats software clear
	// every channel 15 end sets the done flag
	always_ff @(posedge clock) begin
		if (reset) begin
			window_alarm_flag_q  <= STATUS_RESET[ALARM_BIT];
			sequence_done_flag_q <= STATUS_RESET[DONE_BIT];
			alarm_mask_q         <= STATUS_RESET[ALARM_EN_BIT];
			done_mask_q          <= STATUS_RESET[DONE_EN_BIT];
			priority_level_q     <= STATUS_RESET[PRIO_LSB +: PRIO_W];
		end else if (wr_status) begin
			window_alarm_flag_q  <= bus.wdata[ALARM_BIT] || (|new_flags);
			sequence_done_flag_q <= bus.wdata[DONE_BIT] || last_done;
			alarm_mask_q         <= bus.wdata[ALARM_EN_BIT];
			done_mask_q          <= bus.wdata[DONE_EN_BIT];
			priority_level_q     <= bus.wdata[PRIO_LSB +: PRIO_W];
		end else begin
			window_alarm_flag_q  <= window_alarm_flag_q || (|new_flags);
			sequence_done_flag_q <= sequence_done_flag_q || last_done;
		end
	end

	assign alarm_pend = window_alarm_flag_q && alarm_mask_q;
	assign done_pend  = sequence_done_flag_q && done_mask_q;

	// watchdog first, done stays flagged until served
	always_ff @(posedge clock) begin
		if (reset) begin
			irq_request_q  <= 1'b0;
			irq_watchdog_q <= 1'b0;
			irq_level_q    <= 3'h0;
		end else begin
			irq_request_q  <= alarm_pend || done_pend;
			irq_watchdog_q <= alarm_pend;
			irq_level_q    <= priority_level_q;
		end
	end

	// analog side strobes, one cycle behind the sequencer state
	always_ff @(posedge clock) begin
		if (reset) begin
			analog_channel_q <= 4'h0;
			sampling_q       <= 1'b0;
			converting_q     <= 1'b0;
			power_enable_q   <= 1'b0;
		end else begin
			analog_channel_q <= chan_q;
			sampling_q       <= state_q == SEQ_SAMPLE;
			converting_q     <= state_q == SEQ_CONVERT;
			power_enable_q   <= power_on_q;
		end
	end

	// high byte bits 9:2, low byte bits 1:0 on top
	always_comb begin
		read_value = 8'h00;
		if (bus.addr <= ADDR_DATA_LAST) begin
			read_value = bus.addr[0] ? {read_result[1:0], 6'h00} : read_result[9:2];
		end else if (bus.addr[7:2] == ADDR_THRESH_BASE[7:2]) begin
			read_value = threshold_q[bus.addr[1:0]];
		end else if (hit(bus.addr, ADDR_STATUS)) begin
			read_value = {window_alarm_flag_q, sequence_done_flag_q, alarm_mask_q,
				done_mask_q, 1'b0, priority_level_q};
		end else if (hit(bus.addr, ADDR_COMPARE)) begin
			read_value = {compare_flags_q, 4'h0};
		end else if (hit(bus.addr, ADDR_CONTROL_ONE)) begin
			read_value = {watchdog_channel_select_q, first_channel_field_q};
		end else if (hit(bus.addr, ADDR_CONTROL_TWO)) begin
			read_value = {clock_divider_field_q, power_on_q, conversion_run_bit_q,
				repeat_mode_q, external_trigger_mask_q, timer_trigger_mask_q};
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (reset) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= bus.rd ? read_value : 8'h00;
		end
	end

	sequence last_single_s;
		last_done && !repeat_mode_q && !wr_ctl2;
	endsequence
	sequence last_repeat_s;
		last_done && repeat_mode_q;
	endsequence

	single_stop_a: assert property (@(posedge clock) disable iff (reset)
		last_single_s |=> !conversion_run_bit_q && state_q == SEQ_IDLE)
		else $error("single mode did not stop after channel 15");
	repeat_loop_a: assert property (@(posedge clock) disable iff (reset)
		last_repeat_s |=> state_q == SEQ_SAMPLE && chan_q == $past(first_channel_field_q))
		else $error("continuous mode did not restart at first channel");
	chan_step_a: assert property (@(posedge clock) disable iff (reset)
		conv_done && chan_q != LAST_CHANNEL |=> chan_q == $past(chan_q) + 4'h1)
		else $error("channel did not step by one");
	done_flag_a: assert property (@(posedge clock) disable iff (reset)
		last_done |=> sequence_done_flag_q)
		else $error("done flag missing after channel 15");
	trigger_start_a: assert property (@(posedge clock) disable iff (reset)
		trigger_event && !conversion_run_bit_q |=> conversion_run_bit_q)
		else $error("enabled trigger did not set run bit");
	sample_phase_a: assert property (@(posedge clock) disable iff (reset)
		state_q == SEQ_SAMPLE && active && unit_tick && unit_count_q == SAMPLE_UNITS - 5'h01
		|=> state_q == SEQ_CONVERT && unit_count_q == SAMPLE_UNITS)
		else $error("sampling phase not eight units");
	watchdog_first_a: assert property (@(posedge clock) disable iff (reset)
		alarm_pend && done_pend |=> irq_request_q && irq_watchdog_q)
		else $error("watchdog request not served first");
	power_idle_a: assert property (@(posedge clock) disable iff (reset)
		!power_on_q ##1 !power_on_q |-> state_q == SEQ_IDLE)
		else $error("sequencer ran while powered down");
	trigger_block_a: assert property (@(posedge clock) disable iff (reset)
		conversion_run_bit_q && state_q == SEQ_CONVERT && !conv_done && active
		|=> $stable(chan_q))
		else $error("trigger disturbed a running scan");
endmodule : adc_autoscan_sequencer

// ### adc_far_side_model.sv
// far-side model: analog inputs feeding the converter, trigger pin and timer
`timescale 1ns/10ps
module adc_far_side_model (
	input  wire logic       clock,
	input  wire logic [3:0] analog_channel_q,
	input  wire logic       sampling_q,
	input  wire logic       converting_q,
	input  wire logic [5:0] salt,
	output logic [9:0]      conv_result,
	output logic            external_trigger_input,
	output logic            timer_trigger_input
);
	// ten bit per channel
	// the value names its channel; outside a conversion it is inverted so stale data shows
	assign conv_result = (sampling_q | converting_q) ? {analog_channel_q, salt}
		: ~{analog_channel_q, salt};

	initial begin
		external_trigger_input = 1'b1;
		timer_trigger_input    = 1'b1;
	end

	// one source only: each pulse drives a single trigger line low
	task automatic pulse(input bit pin, input int n);
		@(posedge clock);
		if (pin) begin
			external_trigger_input <= 1'b0;
		end else begin
			timer_trigger_input <= 1'b0;
		end
		repeat (n) @(posedge clock);
		external_trigger_input <= 1'b1;
		timer_trigger_input    <= 1'b1;
	endtask : pulse
endmodule : adc_far_side_model

// ### adc_pkg.sv
// shared constants, register map and carrier types of the converter sequencer
package adc_pkg;
	localparam int       CHANNELS     = 16;
	localparam int       CHAN_W       = 4;
	localparam int       RESULT_W     = 10;
	localparam int       DIV_W        = 3;
	localparam int       PRIO_W       = 3;
	// register byte offsets
	localparam logic [7:0] ADDR_DATA_BASE    = 8'h00;
	localparam logic [7:0] ADDR_DATA_LAST    = 8'h1f;
	localparam logic [7:0] ADDR_THRESH_BASE  = 8'h20;
	localparam logic [7:0] ADDR_STATUS       = 8'h24;
	localparam logic [7:0] ADDR_COMPARE      = 8'h25;
	localparam logic [7:0] ADDR_CONTROL_ONE  = 8'hfc;
	localparam logic [7:0] ADDR_CONTROL_TWO  = 8'hfd;
	// adc_control_two fields
	localparam int       DIV_LSB      = 5;
	localparam int       POWER_BIT    = 4;
	localparam int       RUN_BIT      = 3;
	localparam int       REPEAT_BIT   = 2;
	localparam int       EXT_MASK_BIT = 1;
	localparam int       TMR_MASK_BIT = 0;
	// adc_control_one fields
	localparam int       WDSEL_LSB    = 4;
	localparam int       FIRST_LSB    = 0;
	// status fields
	localparam int       ALARM_BIT    = 7;
	localparam int       DONE_BIT     = 6;
	localparam int       ALARM_EN_BIT = 5;
	localparam int       DONE_EN_BIT  = 4;
	localparam int       PRIO_LSB     = 0;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] THRESH_RESET  = 8'h00;
	// conversion timing in converter clock units
	localparam logic [4:0] SAMPLE_UNITS = 5'h08;
	localparam logic [4:0] CONV_UNITS   = 5'h1c;
	localparam logic [3:0] LAST_CHANNEL = 4'hf;
	// trigger history: high then two lows
	localparam logic [2:0] TRIG_IDLE    = 3'h7;
	localparam logic [2:0] TRIG_SEEN    = 3'h4;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_bus_type;

	typedef struct packed {
		logic                en;
		logic [CHAN_W-1:0]   chan;
		logic [RESULT_W-1:0] data;
	} result_write_type;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_SAMPLE  = 2'b01,
		SEQ_CONVERT = 2'b10
	} seq_state_type;
endpackage : adc_pkg

// ### adc_result_store.sv
// per-channel conversion result memory, one word holds both register halves
`timescale 1ns/10ps
module adc_result_store #(
	parameter int DEPTH = adc_pkg::CHANNELS
) (
	input  wire logic                         clock,
	input  wire adc_pkg::result_write_type    write,
	input  wire logic [adc_pkg::CHAN_W-1:0]   read_chan,
	output logic      [adc_pkg::RESULT_W-1:0] read_data
);
	import adc_pkg::*;
	logic [RESULT_W-1:0] mem [DEPTH];

	if (DEPTH != (1 << CHAN_W)) begin : depth_check
		$error("result store depth must match the channel field");
	end

	always_ff @(posedge clock) begin
		if (write.en) begin
			mem[write.chan] <= write.data;
		end
	end

	assign read_data = mem[read_chan];
endmodule : adc_result_store

// ### adc_unit_prescaler.sv
// converter clock divider producing the conversion unit tick
`timescale 1ns/10ps
module adc_unit_prescaler (
	input  wire logic                     clock,
	input  wire logic                     reset,
	input  wire logic                     enable,
	input  wire logic [adc_pkg::DIV_W-1:0] divider,
	output logic                          unit_tick_q,
	output logic                          converter_clock_q
);
	import adc_pkg::*;
	logic [DIV_W-1:0] count_q;
	logic [DIV_W-1:0] limit;

	// a zero divider would stall the unit; it is served as one
	assign limit = (divider == 3'h0) ? 3'h1 : divider;

	always_ff @(posedge clock) begin
		if (reset || !enable) begin
			count_q           <= 3'h0;
			converter_clock_q <= 1'b0;
			unit_tick_q       <= 1'b0;
		end else begin
			unit_tick_q <= 1'b0;
			if (count_q == limit - 3'h1) begin
				count_q           <= 3'h0;
				converter_clock_q <= ~converter_clock_q;
				unit_tick_q       <= converter_clock_q; // end of a full period
			end else begin
				count_q <= count_q + 3'h1;
			end
		end
	end

	// with the smallest divider a unit is two cycles, so one quiet cycle is the floor
	tick_spacing_a: assert property (@(posedge clock) disable iff (reset)
		unit_tick_q |=> !unit_tick_q)
		else $error("unit ticks on two adjacent cycles");
endmodule : adc_unit_prescaler

// ### test_adc_autoscan_sequencer.sv
// self-checking bench of the converter sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module test_adc_autoscan_sequencer;
	import adc_pkg::*;
	logic                  clock;
	logic                  reset;
	reg_bus_type           bus;
	logic [7:0]            rd_data_q;
	logic                  ext_trg;
	logic                  tmr_trg;
	logic [RESULT_W-1:0]   conv_result;
	logic [CHAN_W-1:0]     analog_channel_q;
	logic                  sampling_q;
	logic                  converting_q;
	logic                  power_enable_q;
	logic                  converter_clock;
	logic                  irq_request_q;
	logic                  irq_watchdog_q;
	logic [PRIO_W-1:0]     irq_level_q;
	logic [5:0]            salt;
	logic [7:0]            v;
	int                    n_errors;
	int                    compares;
	int                    k;

	adc_autoscan_sequencer u_adc_autoscan_sequencer (.clock(clock), .reset(reset), .bus(bus),
		.rd_data_q(rd_data_q), .external_trigger_input(ext_trg), .timer_trigger_input(tmr_trg),
		.conv_result(conv_result), .analog_channel_q(analog_channel_q), .sampling_q(sampling_q),
		.converting_q(converting_q), .power_enable_q(power_enable_q),
		.converter_clock(converter_clock), .irq_request_q(irq_request_q),
		.irq_watchdog_q(irq_watchdog_q), .irq_level_q(irq_level_q));
	adc_far_side_model u_adc_far_side_model (.clock(clock), .analog_channel_q(analog_channel_q),
		.sampling_q(sampling_q), .converting_q(converting_q), .salt(salt),
		.conv_result(conv_result), .external_trigger_input(ext_trg),
		.timer_trigger_input(tmr_trg));

	// 125 MHz system clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// one-cycle strobes; a gap edge follows so strobes never collide in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus <= '0;
		#1 d = rd_data_q;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask : rchk
	function automatic logic [7:0] ctl2(input int dv, input bit pw, rn, rp, em, tm);
		return 8'((dv << DIV_LSB) | (pw << POWER_BIT) | (rn << RUN_BIT) | (rp << REPEAT_BIT)
			| (em << EXT_MASK_BIT) | (tm << TMR_MASK_BIT));
	endfunction : ctl2
	// bounded poll until the run bit drops
	task automatic wait_idle();
		logic [7:0] d;
		for (k = 0; k < 2000; k++) begin
			rd(ADDR_CONTROL_TWO, d);
			if (d[RUN_BIT] === 1'b0) break;
		end
		if (k == 2000) begin
			n_errors++;
			results();
		end
	endtask : wait_idle
	task automatic chk_result(input int ch, input logic [5:0] s);
		rchk(8'(2 * ch), {4'(ch), s[5:2]});
		rchk(8'(2 * ch + 1), {s[1:0], 6'h00});
	endtask : chk_result

	// reset values and unmapped reads
	task automatic t_reset();
		rchk(ADDR_CONTROL_ONE, CONTROL_RESET);
		rchk(ADDR_CONTROL_TWO, CONTROL_RESET);
		rchk(ADDR_STATUS, STATUS_RESET);
		rchk(8'h80, 8'h00);
	endtask : t_reset

	// single scan from channel 14, then channel 15 alone overwrites only its own pair
	task automatic t_single();
		salt = 6'h2d;
		wr(ADDR_CONTROL_ONE, 8'h0e);
		wr(ADDR_CONTROL_TWO, ctl2(0, 1, 1, 0, 0, 0));
		wait_idle();
		chk_result(14, 6'h2d);
		chk_result(15, 6'h2d);
		rchk(ADDR_STATUS, 8'h40);
		`CHK(power_enable_q, 1'b1)
		salt = 6'h13;
		wr(ADDR_CONTROL_ONE, 8'h0f);
		wr(ADDR_CONTROL_TWO, ctl2(0, 1, 1, 0, 0, 0));
		wait_idle();
		chk_result(14, 6'h2d);
		chk_result(15, 6'h13);
	endtask : t_single

	// masked and unmasked timer trigger, unmasked pin trigger
	task automatic t_trigger();
		wr(ADDR_CONTROL_TWO, ctl2(0, 1, 0, 0, 1, 0));
		u_adc_far_side_model.pulse(1'b0, 4);
		rchk(ADDR_CONTROL_TWO, ctl2(0, 1, 0, 0, 1, 0));
		u_adc_far_side_model.pulse(1'b1, 4);
		rchk(ADDR_CONTROL_TWO, ctl2(0, 1, 1, 0, 1, 0));
		wait_idle();
		wr(ADDR_CONTROL_TWO, ctl2(0, 1, 0, 0, 0, 1));
		u_adc_far_side_model.pulse(1'b0, 4);
		rchk(ADDR_CONTROL_TWO, ctl2(0, 1, 1, 0, 0, 1));
		wait_idle();
	endtask : t_trigger

	// continuous mode with divider 2: phase lengths and clock high phase
	task automatic t_continuous();
		int n;
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL_TWO, ctl2(2, 1, 1, 1, 0, 0));
		for (n = 0; n < 400 && sampling_q !== 1'b1; n++) @(posedge clock);
		for (n = 0; n < 400 && sampling_q === 1'b1; n++) @(posedge clock);
		`CHK(n, 32)
		for (n = 0; n < 400 && converting_q === 1'b1; n++) @(posedge clock);
		`CHK(n, 80)
		// bounded wait for the converter clock high phase, then count the cycles it stays high
		for (n = 0; n < 40 && converter_clock !== 1'b1; n++) @(posedge clock);
		for (n = 0; n < 40 && converter_clock === 1'b1; n++) @(posedge clock);
		`CHK(n, 2)
		repeat (300) @(posedge clock);
		rchk(ADDR_CONTROL_TWO, ctl2(2, 1, 1, 1, 0, 0));
		rchk(ADDR_STATUS, 8'h40);
		wr(ADDR_CONTROL_TWO, ctl2(2, 1, 0, 1, 0, 0));
		repeat (3) @(posedge clock);
		`CHK(sampling_q | converting_q, 1'b0)
	endtask : t_continuous

	// watchdog pair 15 and 0, only channel 15 converted; priority between requests
	task automatic t_watchdog();
		wr(ADDR_THRESH_BASE, 8'hff);
		wr(8'(ADDR_THRESH_BASE + 1), 8'hff);
		wr(ADDR_CONTROL_ONE, 8'hff);
		wr(ADDR_CONTROL_TWO, ctl2(0, 1, 1, 0, 0, 0));
		wait_idle();
		rchk(ADDR_COMPARE, 8'h40);
		wr(ADDR_STATUS, 8'hf5);
		repeat (3) @(posedge clock);
		`CHK(irq_request_q, 1'b1)
		`CHK(irq_watchdog_q, 1'b1)
		`CHK(irq_level_q, 3'h5)
		wr(ADDR_STATUS, 8'h75);
		repeat (3) @(posedge clock);
		`CHK(irq_watchdog_q, 1'b0)
		`CHK(irq_request_q, 1'b1)
		rchk(ADDR_COMPARE, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL_TWO, 8'h00);
		repeat (3) @(posedge clock);
		`CHK(irq_request_q, 1'b0)
		`CHK(power_enable_q, 1'b0)
	endtask : t_watchdog

	// verdict and end of run
	task automatic results();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	initial begin
		reset = 1'b1;
		bus = '0;
		salt = 6'h00;
		n_errors = 0;
		compares = 0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_reset();
		t_single();
		t_trigger();
		t_continuous();
		t_watchdog();
		results();
	end
endmodule : test_adc_autoscan_sequencer
